/* File: logic/i2c_port_pkg.sv */
/*
  Shared constants, types and the strap decode for the two-wire register
  port: the slave end and the bus master end both import this package.
  Assumes a bus with pull-ups resolved by the carrier interface.
*/
// Notes on behaviour
// - Slave never drives or stretches the clock.
// - Bus runs at most 400 kbit/s.
// - Data changes only while clock is low.
// - Falling data, clock high: START, bus busy.
// - Rising data, clock high: STOP, return idle.
// - Master starts only on a free bus or on its own held bus.
// - Seven-bit address from two three-state straps.
// - Strap pairs map to nine fixed addresses.
// - Address byte ends in direction bit.
// - Slave selected only on address match.
// - Ninth clock carries the acknowledge, held low.
// - Addressed receiver acknowledges every accepted byte.
// - Master reader refuses the final byte.
// - Slave releases data after master refusal.
// - Command byte low six bits select register.
// - Single write: address, command, data, acknowledged.
// - Unknown register refused after command, no write.
// - Command bit six enables address auto-increment.
// - Repeated START chains writes; each byte stored.
package i2c_port_pkg;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  localparam int unsigned REG_SEL_W = 6;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned CMD_AUTO_POS = 6;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_PREFIX = 4'hA;
  localparam logic [6:0] ADDR_BOTH_FLOAT = 7'h58;

  typedef enum logic [1:0] {
    STRAP_LOW = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_FLOAT = 2'h2
  } strap_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_NS = 25;
  localparam int unsigned FAST_MODE_KBPS = 400;
  localparam int unsigned SCL_QUARTER_NS = 1000000 / (FAST_MODE_KBPS * 4);
  localparam int unsigned QUARTER_CYC =
    (SCL_QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  function automatic logic [6:0] strap_address(input logic [1:0] hi,
                                               input logic [1:0] lo);
    logic hf;
    logic lf;
    logic [2:0] code;
    hf = (hi != STRAP_LOW) && (hi != STRAP_HIGH);
    lf = (lo != STRAP_LOW) && (lo != STRAP_HIGH);
    case ({hf, lf})
      2'b00: code = {1'b0, hi == STRAP_HIGH, lo == STRAP_HIGH};
      2'b01: code = (hi == STRAP_HIGH) ? 3'h6 : 3'h4;
      2'b10: code = (lo == STRAP_HIGH) ? 3'h7 : 3'h5;
      default: code = 3'h0;
    endcase
    return ({hf, lf} == 2'b11) ? ADDR_BOTH_FLOAT : {ADDR_PREFIX, code};
  endfunction

endpackage

/* File: logic/i2c_bus_if.sv */
/*
  Two-wire bus carrier joining the master end and the slave end.
  Assumes open-drain pins: each driver only pulls low, pull-ups assumed.
*/
`timescale 1ns/1ps
interface i2c_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // Wired-AND resolution of the pulled-up lines
  // ----------------------------------------------------------------
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport device (
    output s_sda_o,
    output s_sda_oe,
    input scl,
    input sda
  );
endinterface

/* File: logic/i2c_slave_port.sv */
/*
  Slave end of the two-wire register port: address match from straps,
  command byte, single and auto-increment writes, read-back streaming.
  Assumes link_clk is free running and much faster than the bus clock;
  the bus lines and straps are asynchronous to it.
*/
`timescale 1ns/1ps
module i2c_slave_port #(
  parameter int unsigned REG_COUNT = i2c_port_pkg::REG_COUNT
) (
  input wire logic link_clk,
  input wire logic reset_n,
  i2c_bus_if.device bus,
  input wire logic [1:0] address_strap_high,
  input wire logic [1:0] address_strap_low,
  output logic wr_strobe,
  output logic [i2c_port_pkg::REG_SEL_W-1:0] wr_index,
  output logic [7:0] wr_data,
  output logic bus_busy,
  output logic selected
);
  import i2c_port_pkg::*;

  localparam int unsigned IDX_W = $clog2(REG_COUNT);
  localparam logic [REG_SEL_W-1:0] LAST_REG = REG_SEL_W'(REG_COUNT - 1);

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_CMD = 10'h008,
    ST_CMD_ACK = 10'h010,
    ST_DATA = 10'h020,
    ST_DATA_ACK = 10'h040,
    ST_TX = 10'h080,
    ST_TX_ACK = 10'h100,
    ST_SKIP = 10'h200
  } slave_state_e;

  slave_state_e state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_hold;
  logic sda_hold;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;
  logic [3:0] strap_sync0;
  logic [3:0] strap_sync1;
  logic [6:0] own_addr;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_sh;
  logic drive_low;
  logic rw;
  logic auto_inc;
  logic master_ack;
  logic [REG_SEL_W-1:0] ptr;
  logic [REG_SEL_W-1:0] ptr_next;
  logic [REG_SEL_W-1:0] tx_ptr;
  logic [7:0] reg_file [REG_COUNT];
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic wr_fire;

  // ----------------------------------------------------------------
  // Line synchronisers and glitch filter
  // ----------------------------------------------------------------
  // A level is accepted only after two equal samples past the
  // synchroniser, which rejects single-sample spikes on the lines.
  always_ff @(posedge link_clk) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hold <= 1'b1;
      sda_hold <= 1'b1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_hold <= scl_sync[1];
      sda_hold <= sda_sync[1];
      if (scl_sync[1] == scl_hold) begin
        scl_f <= scl_sync[1];
      end
      if (sda_sync[1] == sda_hold) begin
        sda_f <= sda_sync[1];
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // ----------------------------------------------------------------
  // Strap sensing
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!reset_n) begin
      strap_sync0 <= 4'h0;
      strap_sync1 <= 4'h0;
      own_addr <= 7'h00;
    end else begin
      strap_sync0 <= {address_strap_high, address_strap_low};
      strap_sync1 <= strap_sync0;
      own_addr <= strap_address(strap_sync1[3:2], strap_sync1[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_cond = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_cond = scl_f & scl_p & ~sda_p & sda_f;
  assign byte_done = scl_fall && (bit_cnt == BIT_COUNT_BYTE);
  assign ptr_next = (ptr == LAST_REG) ? '0 : ptr + 1'b1;
  assign tx_ptr = auto_inc ? ptr_next : ptr;
  assign wr_fire = !start_cond && !stop_cond && (state == ST_DATA) &&
                   byte_done;

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_sh <= 8'h00;
      drive_low <= 1'b0;
      rw <= 1'b0;
      auto_inc <= 1'b0;
      master_ack <= 1'b0;
      ptr <= '0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      drive_low <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      drive_low <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_CMD, ST_DATA: begin
          shift <= {shift[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_TX: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_TX_ACK: begin
          master_ack <= ~sda_f;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (byte_done && shift[7:1] == own_addr) begin
            state <= ST_ADDR_ACK;
            rw <= shift[0];
            drive_low <= 1'b1;
          end else if (byte_done) begin
            state <= ST_SKIP;
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            state <= ST_TX;
            tx_sh <= reg_file[ptr[IDX_W-1:0]];
            drive_low <= ~reg_file[ptr[IDX_W-1:0]][7];
          end else begin
            state <= ST_CMD;
            drive_low <= 1'b0;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            ptr <= shift[REG_SEL_W-1:0];
            auto_inc <= shift[CMD_AUTO_POS];
            if (shift[REG_SEL_W-1:0] <= LAST_REG) begin
              state <= ST_CMD_ACK;
              drive_low <= 1'b1;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            state <= ST_DATA_ACK;
            drive_low <= 1'b1;
            if (auto_inc) begin
              ptr <= ptr_next;
            end
          end
        end
        ST_CMD_ACK, ST_DATA_ACK: begin
          state <= ST_DATA;
          bit_cnt <= 4'h0;
          drive_low <= 1'b0;
        end
        ST_TX: begin
          if (bit_cnt == BIT_COUNT_BYTE) begin
            state <= ST_TX_ACK;
            drive_low <= 1'b0;
          end else begin
            drive_low <= ~tx_sh[6];
            tx_sh <= {tx_sh[6:0], 1'b0};
          end
        end
        ST_TX_ACK: begin
          bit_cnt <= 4'h0;
          if (master_ack) begin
            state <= ST_TX;
            ptr <= tx_ptr;
            tx_sh <= reg_file[tx_ptr[IDX_W-1:0]];
            drive_low <= ~reg_file[tx_ptr[IDX_W-1:0]][7];
          end else begin
            state <= ST_SKIP;
            drive_low <= 1'b0;
          end
        end
        default: begin
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register store and write report
  // ----------------------------------------------------------------
  // Each acknowledged data byte lands here, so chained writes after a
  // repeated START update one register per byte.
  always_ff @(posedge link_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        reg_file[i] <= REG_RESET;
      end
      wr_strobe <= 1'b0;
      wr_index <= '0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= wr_fire;
      if (wr_fire) begin
        reg_file[ptr[IDX_W-1:0]] <= shift;
        wr_index <= ptr;
        wr_data <= shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!reset_n) begin
      bus_busy <= 1'b0;
    end else if (start_cond) begin
      bus_busy <= 1'b1;
    end else if (stop_cond) begin
      bus_busy <= 1'b0;
    end
  end

  assign selected = (state != ST_IDLE) && (state != ST_ADDR) &&
                    (state != ST_SKIP);

  // The slave only ever pulls data low; the clock is never touched.
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = drive_low;

endmodule

/* File: logic/i2c_master_port.sv */
/*
  Master end of the two-wire register port: single write with STOP or
  held bus for a repeated START, and a one-byte read ending in refusal.
  Assumes sys_clk at the package rate; the bus clock is divided from it.
*/
`timescale 1ns/1ps
module i2c_master_port #(
  parameter int unsigned QUARTER_CYC = i2c_port_pkg::QUARTER_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  i2c_bus_if.master bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [6:0] req_addr,
  input wire logic req_read,
  input wire logic req_hold,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_data,
  output logic done,
  output logic done_nack,
  output logic [7:0] rd_data
);
  import i2c_port_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(QUARTER_CYC - 1);

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_COND = 4'h2,
    M_BYTE = 4'h4,
    M_STOP = 4'h8
  } master_state_e;

  master_state_e state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [15:0] q_cnt;
  logic [1:0] phase;
  logic [3:0] bit_idx;
  logic [1:0] byte_no;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] cmd_q;
  logic [7:0] data_q;
  logic read_q;
  logic hold_q;
  logic holding;
  logic ack_low;
  logic scl_low;
  logic sda_low;
  logic next_scl_low;
  logic next_sda_low;
  logic tick;
  logic rx_byte;
  logic last_byte;

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  assign tick = (q_cnt == TICK_LAST);
  assign rx_byte = read_q && (byte_no == 2'h1);
  assign last_byte = read_q ? (byte_no == 2'h1) : (byte_no == 2'h2);
  // Only a free bus or our own held bus may be claimed.
  assign req_ready = (state == M_IDLE) &&
                     (holding || (scl_sync[1] && sda_sync[1]));

  // ----------------------------------------------------------------
  // Pin levels per phase
  // ----------------------------------------------------------------
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    case (state)
      M_COND: begin
        next_scl_low = (phase == 2'h0) || (phase == 2'h3);
        next_sda_low = phase[1];
      end
      M_BYTE: begin
        next_scl_low = (phase == 2'h0) || (phase == 2'h3);
        // Data moves only in phase 0, while the clock is low.
        if (bit_idx < BIT_COUNT_BYTE && !rx_byte) begin
          next_sda_low = ~tx_sh[7];
        end
      end
      M_STOP: begin
        next_scl_low = (phase == 2'h0);
        next_sda_low = !phase[1];
      end
      M_IDLE: begin
        next_scl_low = holding;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_low;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_low;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= M_IDLE;
      q_cnt <= 16'h0000;
      phase <= 2'h0;
      bit_idx <= 4'h0;
      byte_no <= 2'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      read_q <= 1'b0;
      hold_q <= 1'b0;
      holding <= 1'b0;
      ack_low <= 1'b0;
      done <= 1'b0;
      done_nack <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      done <= 1'b0;
      if (state == M_IDLE) begin
        q_cnt <= 16'h0000;
        phase <= 2'h0;
        if (req_valid && req_ready) begin
          state <= M_COND;
          tx_sh <= {req_addr, req_read};
          cmd_q <= req_cmd;
          data_q <= req_data;
          read_q <= req_read;
          hold_q <= req_hold;
          byte_no <= 2'h0;
          bit_idx <= 4'h0;
          done_nack <= 1'b0;
        end
      end else if (!tick) begin
        q_cnt <= q_cnt + 16'h0001;
      end else begin
        q_cnt <= 16'h0000;
        phase <= phase + 2'h1;
        if (state == M_BYTE && phase == 2'h2) begin
          if (bit_idx < BIT_COUNT_BYTE) begin
            rx_sh <= {rx_sh[6:0], sda_sync[1]};
          end else begin
            ack_low <= ~sda_sync[1];
          end
        end
        if (phase == 2'h3) begin
          case (state)
            M_COND: begin
              state <= M_BYTE;
              holding <= 1'b0;
            end
            M_BYTE: begin
              if (bit_idx < BIT_COUNT_BYTE) begin
                bit_idx <= bit_idx + 4'h1;
                tx_sh <= {tx_sh[6:0], 1'b0};
              end else if (!rx_byte && !ack_low) begin
                state <= M_STOP;
                done_nack <= 1'b1;
              end else if (last_byte) begin
                if (rx_byte) begin
                  rd_data <= rx_sh;
                end
                if (hold_q && !rx_byte) begin
                  state <= M_IDLE;
                  holding <= 1'b1;
                  done <= 1'b1;
                end else begin
                  state <= M_STOP;
                end
              end else begin
                byte_no <= byte_no + 2'h1;
                bit_idx <= 4'h0;
                tx_sh <= (byte_no == 2'h0) ? cmd_q : data_q;
              end
            end
            M_STOP: begin
              state <= M_IDLE;
              done <= 1'b1;
            end
            default: begin
              state <= M_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule

/* File: verif/i2c_port_props.sv */
/*
  Checker for the two-wire port: watches the resolved lines and the slave.
  Assumes link_clk samples all signals; reset_n resets both ends.
*/
`timescale 1ns/1ps
module i2c_port_props (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic s_sda_oe,
  input wire logic bus_busy,
  input wire logic selected,
  input wire logic wr_strobe
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!reset_n);

  a_master_clock_only: assert property (scl == !m_scl_oe)
    else $error("clock driven by other than master");
  a_slave_data_stable: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data moved while clock high");
  a_ack_held_low: assert property (
    $rose(scl) && s_sda_oe |-> s_sda_oe [*8])
    else $error("slave low level not held through high phase");
  a_start_sets_busy: assert property (
    scl && $past(scl) && $fell(sda) |-> ##[1:20] bus_busy)
    else $error("start not seen as busy");
  a_stop_clears_busy: assert property (
    scl && $past(scl) && $rose(sda) |-> ##[1:20] !bus_busy)
    else $error("stop did not free the bus");
  a_store_is_acked: assert property (
    $rose(wr_strobe) |-> ##[0:12] s_sda_oe)
    else $error("stored byte not acknowledged");
  a_store_when_chosen: assert property (
    wr_strobe |-> selected)
    else $error("store without being addressed");
  a_idle_released: assert property (!bus_busy |-> !s_sda_oe)
    else $error("slave holds data line on idle bus");

  c_write: cover property ($rose(wr_strobe));
  c_repeat_start: cover property (scl && $fell(sda) && bus_busy);
  c_ack: cover property ($rose(scl) && s_sda_oe);
endmodule

/* File: verif/i2c_slave_register_port_test.sv */
/*
  Bench: the master end talks to the slave end over the shared carrier.
  Assumes one reset for both ends, long enough for the link clock.
*/
`timescale 1ns/1ps
module i2c_slave_register_port_test;
  import i2c_port_pkg::*;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] strap_hi = 2'h0;
  logic [1:0] strap_lo = 2'h0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_hold = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_cmd = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic req_ready, done, done_nack, wr_strobe, bus_busy, selected;
  logic [7:0] rd_data, wr_data, first_byte;
  logic [5:0] wr_index;
  logic [6:0] own_addr;
  logic [13:0] wq[$];
  logic prev_scl = 1'b1;
  logic prev_sda = 1'b1;
  logic ack_bit = 1'b1;
  logic [7:0] shadow [16] = '{default: REG_RESET};
  logic [3:0] rd_ptr = 4'h0;
  logic [31:0] seed = 32'h7788B36F;
  logic [31:0] r;
  int rises = 0;
  int err_count = 0;
  int total_checks = 0;

  i2c_bus_if i2c_bus_if_i ();
  // Short quarters keep the run brief; about four link cycles a quarter
  i2c_master_port #(.QUARTER_CYC(8)) i2c_master_port_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus(i2c_bus_if_i),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_read(req_read), .req_hold(req_hold), .req_cmd(req_cmd),
    .req_data(req_data), .done(done), .done_nack(done_nack),
    .rd_data(rd_data));
  i2c_slave_port i2c_slave_port_i (
    .link_clk(link_clk), .reset_n(reset_n), .bus(i2c_bus_if_i),
    .address_strap_high(strap_hi), .address_strap_low(strap_lo),
    .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
    .bus_busy(bus_busy), .selected(selected));
  i2c_port_props i2c_port_props_i (
    .link_clk(link_clk), .reset_n(reset_n), .scl(i2c_bus_if_i.scl),
    .sda(i2c_bus_if_i.sda), .m_scl_oe(i2c_bus_if_i.m_scl_oe),
    .s_sda_oe(i2c_bus_if_i.s_sda_oe), .bus_busy(bus_busy),
    .selected(selected), .wr_strobe(wr_strobe));

  initial forever #12.5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always @(posedge link_clk) begin
    if (wr_strobe) begin
      wq.push_back({wr_index, wr_data});
    end
  end
  // Counts clock rises since the last start, keeps address byte and ack
  always @(posedge sys_clk) begin
    prev_scl <= i2c_bus_if_i.scl;
    prev_sda <= i2c_bus_if_i.sda;
    if (i2c_bus_if_i.scl && prev_scl && prev_sda && !i2c_bus_if_i.sda) begin
      rises = 0;
    end else if (i2c_bus_if_i.scl && !prev_scl) begin
      if (rises < 8) first_byte = {first_byte[6:0], i2c_bus_if_i.sda};
      if (rises == 8) ack_bit = i2c_bus_if_i.sda;
      rises++;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [6:0] exp_addr(input int h, input int l);
    if (h > 1 && l > 1) return 7'h58;
    if (l > 1) return (h == 1) ? 7'h56 : 7'h54;
    if (h > 1) return (l == 1) ? 7'h57 : 7'h55;
    return {5'h14, h[0], l[0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [6:0] a, input logic rd, input logic hold,
                      input logic [7:0] c, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    req_addr = a;
    req_read = rd;
    req_hold = hold;
    req_cmd = c;
    req_data = d;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 4000);
    @(negedge sys_clk);
    req_valid = 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      err_count++;
      end_of_test();
    end else begin
      repeat (4) @(posedge sys_clk);
    end
  endtask

  task automatic write_chk(input logic [6:0] a, input logic [7:0] c,
                           input logic [7:0] d, input logic hold);
    logic aok;
    logic ok;
    aok = (a == own_addr);
    ok = aok && (c[5:0] < 6'h10);
    // Reads start where the last accepted command left the pointer
    if (ok) begin
      shadow[c[3:0]] = d;
      rd_ptr = c[6] ? 4'(c[3:0] + 4'h1) : c[3:0];
    end
    wq.delete();
    xfer(a, 1'b0, hold, c, d);
    check(16'(first_byte), {8'h00, a, 1'b0});
    check(16'(ack_bit), 16'(!aok));
    check(16'(done_nack), 16'(!ok));
    check(16'(wq.size()), 16'(ok));
    if (ok && wq.size() > 0) check(16'(wq[0]), {2'h0, c[5:0], d});
    if (ok) check(16'(rises), hold ? 16'h001B : 16'h001C);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    int hi_t[9] = '{0, 0, 1, 1, 0, 2, 1, 2, 3};
    int lo_t[9] = '{0, 1, 0, 1, 2, 0, 2, 1, 3};
    // Slave reset must span four link edges, so count link cycles
    repeat (6) @(negedge link_clk);
    reset_n = 1'b1;
    repeat (12) @(negedge link_clk);
    for (int i = 0; i < 9; i++) begin
      @(negedge sys_clk);
      strap_hi = 2'(hi_t[i]);
      strap_lo = 2'(lo_t[i]);
      own_addr = exp_addr(hi_t[i], lo_t[i]);
      repeat (20) @(negedge sys_clk);
      r = rnd();
      write_chk(own_addr, {r[7:6], 2'h0, r[3:0]}, r[15:8], 1'b0);
      write_chk(own_addr ^ 7'h01, r[7:0], r[23:16], 1'b0);
    end
    $display("test straps done");
    write_chk(own_addr, 8'h10, 8'hA5, 1'b0);
    write_chk(own_addr, 8'h3F, 8'h5A, 1'b0);
    write_chk(own_addr, 8'hCF, 8'hFF, 1'b0);
    $display("test command index done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      write_chk(own_addr, {4'h0, r[3:0]}, r[15:8], 1'b1);
      write_chk(own_addr, {4'h4, r[19:16]}, r[31:24], 1'b1);
      xfer(own_addr, 1'b1, 1'b0, 8'h00, 8'h00);
      check(16'(first_byte), {8'h00, own_addr, 1'b1});
      check(16'(rd_data), {8'h00, shadow[rd_ptr]});
      check(16'(bus_busy), 16'h0000);
    end
    $display("test chained writes done");
    end_of_test();
  end
endmodule
